// file: gdm_display_ctrl.sv
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "gdm_defines.svh"

module gdm_display_ctrl
    import gdm_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    // apb register port
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    // processor side
    input  wire gdm_cpu_req_s cpuReq,
    output logic              cpuReady,
    output logic              cpuWait,
    output logic [7:0]        cpuRdata,
    input  wire logic         register_load_strobe,
    input  wire logic         register_select_low,
    input  wire logic         register_select_high,
    // shared display address bus, controller drive
    output logic [15:0]       busAddrOut,
    output logic              busPosOe,
    output logic              busLineOe,
    output logic [3:0]        lineCount,
    // dynamic display memory
    output gdm_dram_s         dram,
    input  wire logic [7:0]   dramRdata,
    // monitor path
    output logic              char_cycle_clock,
    output logic              video_shift_load,
    output logic              videoOut,
    output logic              attrOut,
    output logic              hsync,
    output logic              vsync,
    output logic              vblank,
    output logic              cursorEn
);

    // one clock is one dot; of the seven dots of a character cycle the
    // processor gets the first four and the scan the last three, so the
    // two never meet on the memory pins and need no arbiter
    gdm_state_s  s_q;            // registered state
    gdm_state_s  s_d;            // next state
    logic [10:0] pos;            // current scan position
    logic [10:0] posSum;         // row base plus column, unwrapped
    logic        active;         // scan inside visible area
    logic        cpuSel;         // request aimed at display memory
    logic        cpuPend;        // request not yet served
    logic [14:0] memAddr;        // address of the slot owner
    logic [4:0]  rowLast;        // last row of the frame
    logic [11:0] nextBase;       // row base after a full row
    logic        apbSetup;       // setup cycle of a transfer
    logic        apbWr;          // write taken this edge
    logic        apbHit;         // address maps to a register

    // scan address: base of the text row plus column, kept in 11 bits so it
    // keeps counting through blanking instead of freezing
    assign posSum = s_q.rowBase + {4'h0, s_q.col};
    // the sum passes the last cell in blanking, and once the page has
    // scrolled; both parts stay below one page, so one subtraction folds it
    // limitation: a top or row start above 1919 is not folded back
    assign pos    = (posSum > `GDM_POS_LAST) ? posSum - `GDM_PAGE_SIZE : posSum;
    assign active = (s_q.col < `GDM_COLS) && (s_q.row < `GDM_ROWS);
    assign rowLast = s_q.freq50 ? `GDM_ROW_LAST_50 : `GDM_ROW_LAST_60;
    // one bit wider so that a step past the last cell shows
    assign nextBase = {1'b0, s_q.rowBase} + 12'h050;

    // only requests with the top address bit high belong to this memory
    assign cpuSel  = cpuReq.req && cpuReq.addr[15];
    assign cpuPend = cpuSel && !s_q.cpuDone;

    // one address for whichever owner: the row and column split below then
    // serves processor and scan with the same wiring
    // processor holds the bus in the first four dots, controller in the last three
    assign memAddr = (s_q.phase <= PH_CPU_END) ? cpuReq.addr[14:0]
                                               : {s_q.line, pos};

    // memory strobes decoded from the dot phase
    // not registered again: a copy would lag one dot and push the scan's
    // column strobe into its last dot, too late for the fetch
    always_comb begin
        dram.addr    = 7'h00;
        dram.rasN    = 2'b11;
        dram.casN    = 1'b1;
        dram.weN     = 1'b1;
        dram.wdata   = cpuReq.wdata;
        dram.wdataOe = 1'b0;
        case (s_q.phase)
            PH_CPU_ROW, PH_CTL_ROW: begin
                // row: three low line bits and four low position bits, so the
                // scan itself walks every row and no refresh counter is needed
                dram.addr = {memAddr[13:11], memAddr[3:0]};
            end
            default: begin
                // column: position bits above the bank bit and top line bit
                dram.addr = {memAddr[14], memAddr[10:5]};
            end
        endcase
        case (s_q.phase)
            PH_CPU_ROW, PH_CPU_COL, PH_CPU_HOLD: begin
                // row strobe only for a served request; an idle slot keeps
                // the devices in standby
                if (s_q.cpuBusy) begin
                    dram.rasN[memAddr[4]] = 1'b0;
                    dram.weN     = !cpuReq.write;
                    dram.wdataOe = cpuReq.write;
                end
                if (s_q.phase != PH_CPU_ROW) begin
                    dram.casN = 1'b0;
                end
            end
            PH_CTL_ROW, PH_CTL_COL: begin
                // controller always reads, so write enable stays high
                dram.rasN[memAddr[4]] = 1'b0;
                dram.casN = (s_q.phase == PH_CTL_ROW);
            end
            default: begin
                dram.rasN = 2'b11;
            end
        endcase
    end

    // shared bus: controller drives position and line only in its own slot;
    // the line count also stays on a plain output for the external latch
    // its pins cannot float, so the latch enable copies the position enable
    assign busAddrOut = {1'b1, s_q.line, pos};
    assign busPosOe   = (s_q.phase >= PH_CTL_ROW);
    assign busLineOe  = busPosOe;
    assign lineCount  = s_q.line;

    // processor handshake
    // wait is raised only by a request aimed at this memory, so program
    // fetches and peripheral cycles never stall
    assign cpuReady = s_q.cpuBusy && (s_q.phase == PH_CPU_END);
    assign cpuWait  = cpuPend && !cpuReady;
    assign cpuRdata = s_q.cpuRdata;

    // timing and monitor outputs
    // video, attribute, cursor and shift load gated by the visible tag that travels with each word, so blank cells
    // shift out dark without further decoding
    assign char_cycle_clock = (s_q.phase <= PH_CPU_END);
    assign video_shift_load = (s_q.phase == PH_CTL_END) && s_q.holdTag[1];
    assign videoOut = s_q.shift[6] && s_q.shiftTag[1];
    assign attrOut  = s_q.attr && s_q.shiftTag[1];
    assign cursorEn = s_q.shiftTag[1] && s_q.shiftTag[0];
    assign hsync    = (s_q.col >= `GDM_HS_START) && (s_q.col < `GDM_HS_END);
    assign vsync    = (s_q.row == `GDM_VS_ROW) && (s_q.line < `GDM_VS_LINES);
    assign vblank   = (s_q.row >= `GDM_ROWS);

    // apb: read data caught in setup so it stands from flops in the access phase
    // no wait states; an unmapped offset answers zero with an error
    // instead of leaving the master hanging
    assign apbSetup = psel && !penable;
    assign apbWr    = psel && penable && pwrite;
    assign apbHit   = (paddr == `GDM_OFS_CTRL) || (paddr == `GDM_OFS_TOP) ||
                      (paddr == `GDM_OFS_ROWST) || (paddr == `GDM_OFS_CURSOR) ||
                      (paddr == `GDM_OFS_STATUS);
    assign pready   = psel && penable;
    assign pslverr  = psel && penable && !apbHit;
    assign prdata   = s_q.prdata;

    // next-state logic for the whole controller
    always_comb begin
        s_d = s_q;
        // dot phase: one dot per clock, seven per character cycle
        // it never stops, not even in blanking: refresh rides on the scan
        if (s_q.phase == PH_CTL_END) begin
            s_d.phase = PH_CPU_ROW;
        end else begin
            s_d.phase = gdm_phase_e'(s_q.phase + 3'd1);
        end

        // take a pending request only at the start of its slot
        // a late start inside the slot would cut the row strobe short
        if (s_q.phase == PH_CTL_END) begin
            s_d.cpuBusy = cpuPend;
        end else if (s_q.phase == PH_CPU_END) begin
            s_d.cpuBusy = 1'b0;
        end
        // done is held until the processor drops its strobe
        // otherwise a processor slow to release would be served twice
        if (!cpuSel) begin
            s_d.cpuDone = 1'b0;
        end else if (cpuReady) begin
            s_d.cpuDone = 1'b1;
        end
        // read latch loads only on a served read; idle slots leave it alone
        // sampled in the last processor dot, after two dots of column strobe
        if (s_q.phase == PH_CPU_END && s_q.cpuBusy && !cpuReq.write) begin
            s_d.cpuRdata = dramRdata;
        end

        // controller word: fetch, hold one cycle, then load the shifter
        // the hold stage lines the word up with the start of a shift cycle;
        // the tags move along so visibility and cursor match their dots
        if (s_q.phase == PH_CTL_END) begin
            s_d.fetch    = dramRdata;
            s_d.fetchTag = {active, (pos == s_q.cursor)};
            s_d.hold     = s_q.fetch;
            s_d.holdTag  = s_q.fetchTag;
            s_d.shift    = s_q.hold[6:0];
            s_d.attr     = s_q.hold[7];
            s_d.shiftTag = s_q.holdTag;
        end else begin
            s_d.shift = {s_q.shift[5:0], 1'b0};
        end

        // scan counters advance at the end of every cycle, blanking or not
        // after the tenth line the base moves one row of 80 cells; a pending
        // row start replaces it, and a new frame starts at the top of page
        if (s_q.phase == PH_CTL_END) begin
            if (s_q.col == `GDM_COL_LAST) begin
                s_d.col = 7'h00;
                if (s_q.line == `GDM_LINES - 4'd1) begin
                    s_d.line = 4'h0;
                    if (s_q.row == rowLast) begin
                        s_d.row     = 5'h00;
                        s_d.rowBase = s_q.top;
                    end else begin
                        s_d.row = s_q.row + 5'd1;
                        if (s_q.rowStartPend) begin
                            s_d.rowBase = s_q.rowStart;
                        end else if (nextBase > {1'b0, `GDM_POS_LAST}) begin
                            s_d.rowBase = 11'(nextBase - 12'd1920);
                        end else begin
                            s_d.rowBase = nextBase[10:0];
                        end
                    end
                    s_d.rowStartPend = 1'b0;
                end else begin
                    s_d.line = s_q.line + 4'd1;
                end
            end else begin
                s_d.col = s_q.col + 7'd1;
            end
        end

        // the strobe counts only while the processor owns the bus; in the
        // scan slot the address lines carry the scan position
        // register load from the processor bus during its slot; the address
        // bits carry the value, register_select_high and register_select_low pick the register
        if (register_load_strobe && s_q.phase <= PH_CPU_END) begin
            case ({register_select_high, register_select_low})
                2'b00: s_d.top = cpuReq.addr[10:0];
                2'b01: begin
                    s_d.rowStart     = cpuReq.addr[10:0];
                    s_d.rowStartPend = 1'b1;
                end
                2'b10: s_d.cursor = cpuReq.addr[10:0];
                default: s_d.cursor = s_q.cursor;
            endcase
        end

        // apb writes take priority over a pin load in the same cycle
        // only the low eleven bits of a position register are kept
        if (apbWr) begin
            case (paddr)
                `GDM_OFS_CTRL:   s_d.freq50 = pwdata[`GDM_CTRL_FREQ50];
                `GDM_OFS_TOP:    s_d.top    = pwdata[10:0];
                `GDM_OFS_ROWST: begin
                    s_d.rowStart     = pwdata[10:0];
                    s_d.rowStartPend = 1'b1;
                end
                `GDM_OFS_CURSOR: s_d.cursor = pwdata[10:0];
                default:         s_d.freq50 = s_q.freq50;
            endcase
        end
        // read data caught in setup; the status word is a snapshot of the
        // scan at that cycle
        if (apbSetup) begin
            case (paddr)
                `GDM_OFS_CTRL:   s_d.prdata = {31'h0, s_q.freq50};
                `GDM_OFS_TOP:    s_d.prdata = {21'h0, s_q.top};
                `GDM_OFS_ROWST:  s_d.prdata = {21'h0, s_q.rowStart};
                `GDM_OFS_CURSOR: s_d.prdata = {21'h0, s_q.cursor};
                `GDM_OFS_STATUS: s_d.prdata = {11'h000, vblank, s_q.row, s_q.line, pos};
                default:         s_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // single state register
    // reset lands on the first processor dot, so the first character
    // cycle after release is a whole one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q              <= '0;
            s_q.phase        <= PH_CPU_ROW;
            s_q.freq50       <= `GDM_RST_FREQ50;
            s_q.top          <= `GDM_RST_POS;
            s_q.rowStart     <= `GDM_RST_POS;
            s_q.cursor       <= `GDM_RST_POS;
            s_q.rowBase      <= `GDM_RST_POS;
        end else begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

// file: gdm_defines.svh
`ifndef GDM_DEFINES_SVH
`define GDM_DEFINES_SVH

// screen format, fixed
`define GDM_ROWS          5'd24
`define GDM_COLS          7'd80
`define GDM_LINES         4'd10
`define GDM_DOTS          3'd7
`define GDM_POS_LAST      11'd1919
`define GDM_PAGE_SIZE     11'h780
// horizontal frame in character cycles, blanking included
`define GDM_COL_LAST      7'd99
`define GDM_HS_START      7'd84
`define GDM_HS_END        7'd92
// vertical frame in character rows of ten lines each
`define GDM_ROW_LAST_60   5'd25
`define GDM_ROW_LAST_50   5'd30
`define GDM_VS_ROW        5'd25
`define GDM_VS_LINES      4'd4

// timing figures and their cycle counts at the clock rate
`define GDM_CLK_MHZ       25
`define GDM_T_WAIT_NS     640
`define GDM_T_ACCESS_NS   360
`define GDM_T_REFRESH_US  2000
`define GDM_WAIT_CYC      (`GDM_T_WAIT_NS * `GDM_CLK_MHZ / 1000)
`define GDM_ACCESS_CYC    (`GDM_T_ACCESS_NS * `GDM_CLK_MHZ / 1000)
`define GDM_REFRESH_CYC   (`GDM_T_REFRESH_US * `GDM_CLK_MHZ)

// register offsets, byte addresses
`define GDM_OFS_CTRL      8'h00
`define GDM_OFS_TOP       8'h04
`define GDM_OFS_ROWST     8'h08
`define GDM_OFS_CURSOR    8'h0C
`define GDM_OFS_STATUS    8'h10
// control fields and reset values
`define GDM_CTRL_FREQ50   0
`define GDM_RST_FREQ50    1'b0
`define GDM_RST_POS       11'h000

`endif

// file: gdm_pkg.sv
package gdm_pkg;

    // seven dot times of one character cycle: processor slot then controller slot
    typedef enum logic [2:0] {
        PH_CPU_ROW,
        PH_CPU_COL,
        PH_CPU_HOLD,
        PH_CPU_END,
        PH_CTL_ROW,
        PH_CTL_COL,
        PH_CTL_END
    } gdm_phase_e;

    // processor request toward display memory
    typedef struct packed {
        logic        req;    // memory read or write strobe, level
        logic        write;  // high for a write
        logic [15:0] addr;   // processor address
        logic [7:0]  wdata;  // write data
    } gdm_cpu_req_s;

    // dynamic memory pins, strobes active low
    typedef struct packed {
        logic [6:0] addr;
        logic [1:0] rasN;
        logic       casN;
        logic       weN;
        logic [7:0] wdata;
        logic       wdataOe;
    } gdm_dram_s;

    // whole state of the controller
    typedef struct packed {
        gdm_phase_e  phase;
        logic [6:0]  col;
        logic [3:0]  line;
        logic [4:0]  row;
        logic [10:0] rowBase;
        logic [10:0] top;
        logic [10:0] rowStart;
        logic [10:0] cursor;
        logic        rowStartPend;
        logic        freq50;
        logic        cpuBusy;
        logic        cpuDone;
        logic [7:0]  cpuRdata;
        logic [7:0]  fetch;
        logic [1:0]  fetchTag;
        logic [7:0]  hold;
        logic [1:0]  holdTag;
        logic [6:0]  shift;
        logic        attr;
        logic [1:0]  shiftTag;
        logic [31:0] prdata;
    } gdm_state_s;

endpackage

// file: gdm_display_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// port-level timing checks of the display controller
module gdm_display_ctrl_assertions
    import gdm_pkg::*;
(
    input wire logic         clk,
    input wire logic         arst_n,
    input wire gdm_cpu_req_s cpuReq,
    input wire logic         cpuReady,
    input wire logic         cpuWait,
    input wire logic [15:0]  busAddrOut,
    input wire logic         busPosOe,
    input wire logic         busLineOe,
    input wire logic [3:0]   lineCount,
    input wire gdm_dram_s    dram,
    input wire logic         char_cycle_clock,
    input wire logic         video_shift_load,
    input wire logic         vsync,
    input wire logic         vblank
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // processor owns four dot times, the scan the remaining three
    sequence cpuSlot;
        char_cycle_clock [*4];
    endsequence
    sequence ctlSlot;
        !char_cycle_clock [*3];
    endsequence
    cycle_clock_a: assert property (
        $rose(char_cycle_clock) |-> cpuSlot ##1 ctlSlot ##1 char_cycle_clock)
        else $error("character cycle clock out of step");
    bus_owner_a: assert property (
        busPosOe == !char_cycle_clock && busLineOe == busPosOe)
        else $error("address drive outside the scan slot");
    scan_addr_a: assert property (
        busPosOe |-> busAddrOut[15] && busAddrOut[14:11] == lineCount
            && busAddrOut[10:0] <= 11'd1919)
        else $error("scan address malformed");
    // the scan always strobes a row, blanking included, so refresh never stops
    scan_row_a: assert property (
        $fell(char_cycle_clock) |-> !dram.rasN[busAddrOut[4]] && dram.rasN[!busAddrOut[4]]
            && dram.addr == {busAddrOut[13:11], busAddrOut[3:0]})
        else $error("scan row address or bank wrong");
    scan_col_a: assert property (
        busPosOe && !dram.casN |-> dram.weN && dram.addr == {busAddrOut[14], busAddrOut[10:5]})
        else $error("scan column address wrong");
    write_enable_a: assert property (
        !dram.weN |-> char_cycle_clock && cpuReq.req && cpuReq.write)
        else $error("write enable without processor write");
    wait_bound_a: assert property (
        cpuWait |-> ##[1:10] cpuReady)
        else $error("processor wait too long");
    wait_cause_a: assert property (
        cpuWait |-> cpuReq.req && cpuReq.addr[15])
        else $error("processor stalled without display access");
    ready_slot_a: assert property (
        cpuReady |-> char_cycle_clock ##1 (!char_cycle_clock && !cpuReady))
        else $error("ready outside last processor dot");
    idle_slot_a: assert property (
        $rose(char_cycle_clock) && (&dram.rasN) |-> ##1 (!dram.casN && (&dram.rasN)) ##2 !cpuReady)
        else $error("idle processor slot misbehaves");
    shift_load_a: assert property (
        video_shift_load |-> !char_cycle_clock ##1 $rose(char_cycle_clock))
        else $error("shift load outside last scan dot");
    blank_load_a: assert property (
        vblank || vsync |-> vblank && !video_shift_load)
        else $error("shift load or sync outside blanking");
endmodule

bind gdm_display_ctrl gdm_display_ctrl_assertions i_chk (
    .clk(clk), .arst_n(arst_n), .cpuReq(cpuReq), .cpuReady(cpuReady), .cpuWait(cpuWait),
    .busAddrOut(busAddrOut), .busPosOe(busPosOe), .busLineOe(busLineOe),
    .lineCount(lineCount), .dram(dram), .char_cycle_clock(char_cycle_clock),
    .video_shift_load(video_shift_load), .vsync(vsync), .vblank(vblank));
`default_nettype wire

// file: gdm_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// processor side: holds its strobe until ready or for at most 40 cycles, gap sets the phase of the request
module gdm_cpu_model
    import gdm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       cpuReady,
    input  wire logic [7:0] cpuRdata,
    input  wire logic       charClk,
    output gdm_cpu_req_s    cpuReq,
    output logic            loadStrobe,
    output logic [1:0]      regSel
);
    initial begin
        cpuReq = '0;
        loadStrobe = 1'b0;
        regSel = 2'b11;
    end
    // one whole-word access; at least one idle cycle precedes it
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] wd,
                          input int gap, output logic [7:0] rd, output int waited);
        repeat (gap + 1) @(posedge clk);
        cpuReq <= '{1'b1, wr, a, wd};
        @(posedge clk);
        waited = 1;
        while (cpuReady !== 1'b1 && waited < 40) begin
            @(posedge clk);
            waited++;
        end
        // released lines do not keep their last value
        cpuReq <= '{1'b0, wr, ~a, ~wd};
        // read data is registered at the ready edge, so take it one edge on
        @(posedge clk);
        rd = cpuRdata;
    endtask
    // register load in the processor slot, select driven on its own regSel lines
    task automatic load_reg(input logic [1:0] sel, input logic [10:0] v);
        @(posedge charClk);
        cpuReq.addr <= {5'h00, v};
        regSel <= sel;
        loadStrobe <= 1'b1;
        repeat (2) @(posedge clk);
        loadStrobe <= 1'b0;
        regSel <= ~sel;
    endtask
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
    import gdm_pkg::*;
;
    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic         pready, pslverr, cpuReady, cpuWait, busPosOe, busLineOe;
    logic [31:0]  prdata;
    logic [7:0]   cpuRdata;
    logic [15:0]  busAddrOut;
    logic [3:0]   lineCount;
    logic         ccc, vsl, videoOut, attrOut, hsync, ldStb, curEn;
    logic [1:0]   regSel;
    gdm_cpu_req_s cpuReq;
    gdm_dram_s    dram;
    int           failures = 0;
    int           tests_run = 0;
    logic [7:0]   mem [0:32767];
    logic [6:0]   rowQ;
    logic         bankQ;
    logic [1:0]   rasQ = 2'b11;
    logic [7:0]   outQ = 8'h00;

    always #20 clk = ~clk;
    initial foreach (mem[i]) mem[i] = 8'h00;
    // memory array: row latched as a strobe falls, output held one cycle then scrambled
    always @(posedge clk) begin
        rasQ <= dram.rasN;
        if ((rasQ & ~dram.rasN) != 2'b00) begin
            rowQ <= dram.addr;
            bankQ <= !dram.rasN[1];
        end
        if (!dram.casN && dram.rasN != 2'b11) begin
            if (!dram.weN) mem[{bankQ, rowQ, dram.addr}] <= dram.wdata;
            outQ <= mem[{bankQ, rowQ, dram.addr}];
        end else begin
            outQ <= ~outQ;
        end
    end

    gdm_display_ctrl i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cpuReq(cpuReq), .cpuReady(cpuReady), .cpuWait(cpuWait),
        .cpuRdata(cpuRdata), .register_load_strobe(ldStb), .register_select_low(regSel[0]),
        .register_select_high(regSel[1]), .busAddrOut(busAddrOut), .busPosOe(busPosOe),
        .busLineOe(busLineOe), .lineCount(lineCount), .dram(dram), .dramRdata(outQ),
        .char_cycle_clock(ccc), .video_shift_load(vsl), .videoOut(videoOut),
        .attrOut(attrOut), .hsync(hsync), .vsync(), .vblank(), .cursorEn(curEn));
    gdm_cpu_model i_cpu (.clk(clk), .cpuReady(cpuReady), .cpuRdata(cpuRdata), .charClk(ccc),
        .cpuReq(cpuReq), .loadStrobe(ldStb), .regSel(regSel));

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // word written at line 1, cell 5, shifted out msb first after its scan
    task automatic test_video();
        logic [7:0] rd;
        logic [6:0] bits;
        int         w, n;
        i_cpu.access(1'b1, 16'h8805, 8'hC5, 0, rd, w);
        check("write wait", w inside {[4:11]}, 1);
        n = 0;
        while (!(busPosOe === 1'b1 && busAddrOut === 16'h8805) && n < 2000) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (videoOut !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        check("video delay", n inside {[10:24]}, 1);
        check("attribute", attrOut, 1);
        bits[6] = videoOut;
        for (int k = 5; k >= 0; k--) begin
            @(posedge clk);
            bits[k] = videoOut;
        end
        check("dot word", bits, 7'h45);
    endtask
    // both banks, requests landing in differing phases, back to back
    task automatic test_cpu();
        logic [7:0] rd;
        int         w;
        for (int i = 0; i < 6; i++) i_cpu.access(1'b1, 16'h8003 | 16'(i * 16), 8'(8'h30 + i), i, rd, w);
        for (int i = 0; i < 6; i++) begin
            i_cpu.access(1'b0, 16'h8003 | 16'(i * 16), 8'h00, 5 - i, rd, w);
            check("read back", rd, 8'(8'h30 + i));
            check("read wait", w inside {[4:11]}, 1);
        end
        i_cpu.access(1'b0, 16'h1234, 8'h00, 0, rd, w);
        check("ignored access", w, 40);
    endtask
    task automatic test_regs();
        logic [31:0] rd;
        logic        er;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, rd, er);
            check("reset value", rd, 32'h0);
            apb(1'b1, 8'(4 * i), 32'hFFFFFFFF, rd, er);
            apb(1'b0, 8'(4 * i), 32'h0, rd, er);
            check("register bits", rd, (i == 0) ? 32'h1 : 32'h7FF);
            apb(1'b1, 8'(4 * i), 32'h0, rd, er);
        end
        apb(1'b1, 8'h14, 32'h5, rd, er);
        check("unmapped error", er, 1);
        apb(1'b0, 8'h14, 32'h0, rd, er);
        check("unmapped read", rd, 32'h0);
        for (int i = 0; i < 3; i++) begin
            i_cpu.load_reg(2'(i), 11'(100 + i * 300));
            apb(1'b0, 8'(4 + 4 * i), 32'h0, rd, er);
            check("pin load", rd, 32'(100 + i * 300));
        end
    endtask
    // sync is eight character cycles in a line of one hundred
    task automatic test_hsync();
        int hi, n;
        while (hsync === 1'b1) @(posedge clk);
        n = 0;
        while (hsync !== 1'b1 && n < 800) begin
            @(posedge clk);
            n++;
        end
        hi = 0;
        while (hsync === 1'b1 && hi < 800) begin
            @(posedge clk);
            hi++;
        end
        n = hi;
        while (hsync !== 1'b1 && n < 800) begin
            @(posedge clk);
            n++;
        end
        check("sync width", hi, 56);
        check("line length", n, 700);
    endtask
    // cursor on display position 5, compared with the scan position: lit for one cell of seven dots
    task automatic test_cursor();
        logic [31:0] rd;
        logic        er;
        int          hi;
        apb(1'b1, 8'h0C, 32'h5, rd, er);
        hi = 0;
        while (curEn !== 1'b1 && hi < 800) begin
            @(posedge clk);
            hi++;
        end
        hi = 0;
        while (curEn === 1'b1 && hi < 20) begin
            @(posedge clk);
            hi++;
        end
        check("cursor width", hi, 7);
    endtask
    task automatic wrap_up();
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // the whole sequence needs a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        test_video();
        test_cpu();
        test_regs();
        test_hsync();
        test_cursor();
        wrap_up();
    end
endmodule
`default_nettype wire
